// file: session_auth_framer_consts.svh
`ifndef SESSION_AUTH_FRAMER_CONSTS_SVH
`define SESSION_AUTH_FRAMER_CONSTS_SVH

// session header byte layout
`define HDR_AUTH_BIT     7
`define HDR_FMT_HI       6
`define HDR_FMT_LO       4
`define HDR_TID_HI       3
`define HDR_TID_LO       0

// session format codes
`define FMT_REQUEST      3'h0
`define FMT_RESPONSE     3'h2
`define FMT_PREAMBLE     3'h4
`define FMT_REMINDER     3'h5

// challenge / reply first byte
`define AUTH_CHAL_BITS   2'h0
`define AUTH_REPLY_BITS  2'h2
`define ADDR_FMT_GROUP   2'h1

// member list limits and challenge field length
`define PRE_LEN_MIN      4'h3
`define PRE_LEN_MAX      4'h8
`define REM_LEN_MAX      4'h2
`define PRE_MEMBER_MIN   7'h10
`define AUTH_FIELD_BYTES 4'h8

// reset values
`define LFSR_SEED        64'hA5C3_5A3C_9E37_79B9
`define DIGEST_SEED      64'h6A09_E667_BB67_AE85

`endif

// file: session_auth_framer_pkg.sv
package session_auth_framer_pkg;

	typedef enum logic [2:0] {
		TX_IDLE  = 3'b000,
		TX_HDR   = 3'b001,
		TX_LEN   = 3'b010,
		TX_LIST  = 3'b011,
		TX_PAY   = 3'b100,
		TX_FIELD = 3'b101,
		TX_GROUP = 3'b110
	} tx_state_type;

	typedef enum logic [2:0] {
		RX_HDR   = 3'b000,
		RX_LEN   = 3'b001,
		RX_LIST  = 3'b010,
		RX_BODY  = 3'b011,
		RX_CHAL  = 3'b100,
		RX_CGRP  = 3'b101,
		RX_SKIP  = 3'b110
	} rx_state_type;

	typedef enum logic [1:0] {
		CMD_REQUEST  = 2'b00,
		CMD_RETRY    = 2'b01,
		CMD_RESPONSE = 2'b10
	} cmd_kind_type;

	typedef enum logic [1:0] {
		PKT_SESSION = 2'b00,
		PKT_REMIND2 = 2'b01,
		PKT_CHAL    = 2'b10,
		PKT_REPLY   = 2'b11
	} pkt_kind_type;

endpackage : session_auth_framer_pkg

// file: reply_transform.sv
`include "session_auth_framer_consts.svh"

// folds the original packet, the key and the challenge into an 8-byte reply
module reply_transform (
	input  wire logic        clk,
	input  wire logic        nrst,
	// packet bytes
	input  wire logic        clear,
	input  wire logic        byte_valid,
	input  wire logic [7:0]  byte_data,
	// key and challenge
	input  wire logic [47:0] key,
	input  wire logic [63:0] challenge,
	output logic      [63:0] reply
);
	logic [63:0] digest_q;
	logic [63:0] digest_d;
	logic [63:0] mix;

	always_comb begin
		digest_d = digest_q;
		if (clear) begin
			digest_d = `DIGEST_SEED;
		end else if (byte_valid) begin
			digest_d = {digest_q[56:0], digest_q[63:57]} ^ {56'h0, byte_data};
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			digest_q <= `DIGEST_SEED;
		end else begin
			digest_q <= digest_d;
		end
	end

	// any keyed mix will do here; swap this block for the real transform
	always_comb begin
		mix   = digest_q ^ {key[15:0], key} ^ challenge;
		reply = {mix[40:0], mix[63:41]} ^ {challenge[31:0], challenge[63:32]} ^ {16'h0, key};
	end

endmodule : reply_transform

// file: session_auth_framer.sv
`include "session_auth_framer_consts.svh"

// Functional notes
// - auth bit is 1 for authenticated messages, 0 otherwise.
// - format codes: 0 request, 2 response, 4 preamble, 5 reminder.
// - header-only session packet is legal to send and to parse.
// - code 0 only on the first send; retries use reminder formats.
// - responses to requests go out with format code 2.
// - retry with highest missing member 16 or above sends a preamble first.
// - preamble is followed at once by the original request.
// - preamble length byte is member-list bytes, 3 to 8.
// - member list bit 0 of byte 0 is member 0; 1 means answered.
// - reminder message: length, 0-2 list bytes, then presentation packet.
// - reminder with length 0 asks every member to respond.
// - an authenticated incoming packet triggers a challenge back.
// - challenge: addr format, 00, transaction, 8 random bytes, optional group.
// - addr format coded as in the network header.
// - challenge transaction number copied from the challenged packet.
// - challenge field is 8 random bytes.
// - group byte only when addr format is 1, equal to header group.
// - a received challenge is answered with a reply packet.
// - reply uses bits 10, 8-byte reply, same addr, transaction, group.
// - reply computed from original packet, key and challenge bytes; code digests only payload bytes of authenticated requests.
// - challenge is issued even if authentication is not required.
// - each domain has a 48-bit key feeding the reply.
// - every challenge uses fresh random bytes.
module session_auth_framer
#(
	parameter int LIST_BYTES = 8
) (
	// clock and reset
	input  wire logic                               clk,
	input  wire logic                               nrst,
	// transmit commands
	input  wire logic                               cmd_valid,
	input  wire session_auth_framer_pkg::cmd_kind_type cmd_kind,
	input  wire logic                               cmd_auth,
	input  wire logic [3:0]                         cmd_tid,
	input  wire logic                               cmd_has_pay,
	input  wire logic [3:0]                         cmd_list_len,
	input  wire logic [LIST_BYTES*8-1:0]            cmd_list,
	output logic                                    cmd_ready,
	// presentation payload in
	input  wire logic                               pay_valid,
	input  wire logic [7:0]                         pay_data,
	input  wire logic                               pay_last,
	output logic                                    pay_ready,
	// packet stream out
	output logic                                    out_valid,
	output logic [7:0]                              out_data,
	output logic                                    out_first,
	output logic                                    out_last,
	output session_auth_framer_pkg::pkt_kind_type   out_kind,
	// packet stream in
	input  wire logic                               in_valid,
	input  wire logic [7:0]                         in_data,
	input  wire logic                               in_last,
	input  wire logic                               in_is_chal,
	input  wire logic                               in_is_session,
	input  wire logic [1:0]                         in_addr_fmt,
	input  wire logic [7:0]                         in_dst_group,
	// node identity
	input  wire logic [47:0]                        auth_key,
	input  wire logic [5:0]                         my_member,
	// parse results
	output logic                                    rx_hdr,
	output logic                                    rx_auth,
	output logic [2:0]                              rx_fmt,
	output logic [3:0]                              rx_tid,
	output logic                                    rx_null,
	output logic                                    rx_done,
	output logic                                    rx_solicit,
	output logic                                    rx_err
);
	import session_auth_framer_pkg::*;

	localparam int LW = LIST_BYTES * 8;

	////////////////////////////////////////////////////////////////////////////////
	// receive side state
	rx_state_type    rs_q, rs_d;
	logic [2:0]      rfmt_q, rfmt_d;
	logic [3:0]      rlen_q, rlen_d;
	logic [3:0]      rcnt_q, rcnt_d;
	logic [LW-1:0]   rlist_q, rlist_d;
	logic            hdr_q, hdr_d, auth_q, auth_d, null_q, null_d;
	logic [3:0]      rtid_q, rtid_d;
	logic            done_q, done_d, sol_q, sol_d, err_q, err_d;
	logic            chal_pend_q, chal_pend_d, rep_pend_q, rep_pend_d;
	logic [1:0]      c_af_q, c_af_d;
	logic [3:0]      c_tid_q, c_tid_d;
	logic [7:0]      c_grp_q, c_grp_d;
	logic [1:0]      r_af_q, r_af_d;
	logic [3:0]      r_tid_q, r_tid_d;
	logic [7:0]      r_grp_q, r_grp_d;
	logic [63:0]     rchal_q, rchal_d;
	logic            take_chal, take_rep;

	always_comb begin
		rs_d = rs_q; rfmt_d = rfmt_q; rlen_d = rlen_q; rcnt_d = rcnt_q;
		rlist_d = rlist_q; hdr_d = 1'b0; auth_d = auth_q; null_d = 1'b0;
		rtid_d = rtid_q; done_d = 1'b0; sol_d = sol_q; err_d = 1'b0;
		c_af_d = c_af_q; c_tid_d = c_tid_q; c_grp_d = c_grp_q;
		r_af_d = r_af_q; r_tid_d = r_tid_q; r_grp_d = r_grp_q; rchal_d = rchal_q;
		chal_pend_d = chal_pend_q & ~take_chal;
		rep_pend_d  = rep_pend_q & ~take_rep;
		if (in_valid) begin
			unique case (rs_q)
				RX_HDR: begin
					rcnt_d = 4'h0;
					if (in_is_chal) begin
						// challenge with bits 00 starts reply, whatever its transaction
						r_af_d  = in_data[7:6];
						r_tid_d = in_data[`HDR_TID_HI:`HDR_TID_LO];
						rs_d    = (in_data[5:4] == `AUTH_CHAL_BITS) ? RX_CHAL : RX_SKIP;
					end else begin
						if (in_data[`HDR_AUTH_BIT]) begin
							chal_pend_d = 1'b1;
							c_tid_d = in_data[`HDR_TID_HI:`HDR_TID_LO];
							c_af_d  = in_addr_fmt;
							c_grp_d = in_dst_group;
						end
						rs_d = RX_SKIP;
						if (in_is_session) begin
							hdr_d  = 1'b1;
							auth_d = in_data[`HDR_AUTH_BIT];
							rfmt_d = in_data[`HDR_FMT_HI:`HDR_FMT_LO];
							rtid_d = in_data[`HDR_TID_HI:`HDR_TID_LO];
							sol_d  = 1'b1;
							null_d = in_last;
							unique case (in_data[`HDR_FMT_HI:`HDR_FMT_LO])
								`FMT_REQUEST, `FMT_RESPONSE: rs_d = RX_BODY;
								`FMT_PREAMBLE, `FMT_REMINDER: rs_d = RX_LEN;
								default: err_d = 1'b1;
							endcase
						end
					end
				end
				RX_LEN: begin
					rlen_d  = in_data[3:0];
					rlist_d = '1;
					rs_d    = (in_data == 8'h00) ? RX_BODY : RX_LIST;
					if (rfmt_q == `FMT_PREAMBLE && (in_data < 8'(`PRE_LEN_MIN) ||
							in_data > 8'(`PRE_LEN_MAX))) begin
						err_d = 1'b1;
						rs_d  = RX_SKIP;
					end
					// reminder list is 0 to 2 bytes
					if (rfmt_q == `FMT_REMINDER && in_data > 8'(`REM_LEN_MAX)) begin
						err_d = 1'b1;
						rs_d  = RX_SKIP;
					end
				end
				RX_LIST: begin
					rlist_d[rcnt_q[2:0]*8 +: 8] = in_data;
					rcnt_d = rcnt_q + 4'h1;
					if (rcnt_q + 4'h1 == rlen_q) begin
						rs_d = RX_BODY;
					end
				end
				RX_CHAL: begin
					rchal_d = {in_data, rchal_q[63:8]};
					rcnt_d  = rcnt_q + 4'h1;
					if (rcnt_q + 4'h1 == `AUTH_FIELD_BYTES) begin
						// group byte only for group addressing
						rs_d       = (r_af_q == `ADDR_FMT_GROUP) ? RX_CGRP : RX_SKIP;
						rep_pend_d = (r_af_q != `ADDR_FMT_GROUP);
					end
				end
				RX_CGRP: begin
					r_grp_d    = in_data;
					rep_pend_d = 1'b1;
					rs_d       = RX_SKIP;
				end
				RX_BODY, RX_SKIP: begin
				end
				default: rs_d = RX_SKIP;
			endcase
			if (in_last) begin
				rs_d   = RX_HDR;
				done_d = (rs_q != RX_HDR) || (in_is_session && !in_is_chal);
				// length 0 solicits all; bit 0 means still owed
				if (rs_q != RX_HDR && (rfmt_q == `FMT_PREAMBLE ||
						rfmt_q == `FMT_REMINDER)) begin
					sol_d = (rlen_q == 4'h0) || !rlist_d[my_member];
				end
			end
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			rs_q <= RX_HDR; rfmt_q <= 3'h0; rlen_q <= 4'h0; rcnt_q <= 4'h0;
			rlist_q <= '1; hdr_q <= 1'b0; auth_q <= 1'b0; null_q <= 1'b0;
			rtid_q <= 4'h0; done_q <= 1'b0; sol_q <= 1'b0; err_q <= 1'b0;
			chal_pend_q <= 1'b0; rep_pend_q <= 1'b0;
			c_af_q <= 2'h0; c_tid_q <= 4'h0; c_grp_q <= 8'h00;
			r_af_q <= 2'h0; r_tid_q <= 4'h0; r_grp_q <= 8'h00; rchal_q <= 64'h0;
		end else begin
			rs_q <= rs_d; rfmt_q <= rfmt_d; rlen_q <= rlen_d; rcnt_q <= rcnt_d;
			rlist_q <= rlist_d; hdr_q <= hdr_d; auth_q <= auth_d; null_q <= null_d;
			rtid_q <= rtid_d; done_q <= done_d; sol_q <= sol_d; err_q <= err_d;
			chal_pend_q <= chal_pend_d; rep_pend_q <= rep_pend_d;
			c_af_q <= c_af_d; c_tid_q <= c_tid_d; c_grp_q <= c_grp_d;
			r_af_q <= r_af_d; r_tid_q <= r_tid_d; r_grp_q <= r_grp_d; rchal_q <= rchal_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// reply computation
	logic [63:0] reply_val;
	logic        dig_clear, dig_feed;

	reply_transform u_reply (
		.clk        (clk),
		.nrst       (nrst),
		.clear      (dig_clear),
		.byte_valid (dig_feed),
		.byte_data  (pay_data),
		.key        (auth_key),
		.challenge  (rchal_q),
		.reply      (reply_val)
	);

	////////////////////////////////////////////////////////////////////////////////
	// transmit side state
	tx_state_type  ts_q, ts_d;
	pkt_kind_type  kind_q, kind_d;
	logic [7:0]    hdr_byte_q, hdr_byte_d;
	logic [3:0]    tlen_q, tlen_d, tcnt_q, tcnt_d;
	logic [LW-1:0] tlist_q, tlist_d;
	logic [63:0]   fld_q, fld_d, lfsr_q, lfsr_d;
	logic          auth_t_q, auth_t_d, pay_t_q, pay_t_d, pair_q, pair_d, dig_q, dig_d;
	logic [1:0]    taf_q, taf_d;
	logic [7:0]    tgrp_q, tgrp_d;
	logic          ov_q, ov_d, of_q, of_d, ol_q, ol_d, cr_q, cr_d, pr_q, pr_d;
	logic [7:0]    od_q, od_d;
	logic [6:0]    hi_miss;
	logic          any_miss;

	// highest member still owing a response within the given list
	always_comb begin
		hi_miss  = 7'h0;
		any_miss = 1'b0;
		for (int i = 0; i < LW; i++) begin
			if (4'(i / 8) < cmd_list_len && !cmd_list[i]) begin
				hi_miss  = 7'(i);
				any_miss = 1'b1;
			end
		end
	end

	always_comb begin
		ts_d = ts_q; kind_d = kind_q; hdr_byte_d = hdr_byte_q; tlen_d = tlen_q;
		tcnt_d = tcnt_q; tlist_d = tlist_q; fld_d = fld_q; auth_t_d = auth_t_q;
		pay_t_d = pay_t_q; pair_d = pair_q; taf_d = taf_q; tgrp_d = tgrp_q;
		dig_d = dig_q; ov_d = 1'b0; of_d = 1'b0; ol_d = 1'b0; od_d = od_q;
		take_chal = 1'b0; take_rep = 1'b0; dig_clear = 1'b0; dig_feed = 1'b0;
		// free-running generator, fresh bytes every challenge
		lfsr_d = {lfsr_q[62:0], lfsr_q[63] ^ lfsr_q[62] ^ lfsr_q[60] ^ lfsr_q[59]};
		unique case (ts_q)
			TX_IDLE: begin
				tcnt_d = 4'h0;
				if (rep_pend_q) begin
					// reply bits 10 and challenge's fields
					take_rep   = 1'b1;
					kind_d     = PKT_REPLY;
					hdr_byte_d = {r_af_q, `AUTH_REPLY_BITS, r_tid_q};
					taf_d      = r_af_q;
					tgrp_d     = r_grp_q;
					fld_d      = reply_val;
					ts_d       = TX_HDR;
				end else if (chal_pend_q) begin
					// challenge byte layout with bits 00
					take_chal  = 1'b1;
					kind_d     = PKT_CHAL;
					hdr_byte_d = {c_af_q, `AUTH_CHAL_BITS, c_tid_q};
					taf_d      = c_af_q;
					tgrp_d     = c_grp_q;
					fld_d      = lfsr_q;
					ts_d       = TX_HDR;
				end else if (cmd_valid && cr_q) begin
					kind_d   = PKT_SESSION;
					auth_t_d = cmd_auth;
					pay_t_d  = cmd_has_pay;
					pair_d   = 1'b0;
					tlist_d  = cmd_list;
					ts_d     = TX_HDR;
					// code 0 only on first send
					hdr_byte_d = {cmd_auth, `FMT_REQUEST, cmd_tid};
					if (cmd_kind == CMD_REQUEST) begin
						dig_clear = 1'b1;
						dig_d     = cmd_auth;
					end else begin
						dig_d = 1'b0;
					end
					if (cmd_kind == CMD_RESPONSE) begin
						hdr_byte_d = {cmd_auth, `FMT_RESPONSE, cmd_tid};
					end else if (cmd_kind == CMD_RETRY) begin
						if (any_miss && hi_miss >= `PRE_MEMBER_MIN) begin
							hdr_byte_d = {cmd_auth, `FMT_PREAMBLE, cmd_tid};
							tlen_d     = cmd_list_len;
							pair_d     = 1'b1;
						end else begin
							// reminder with 1- or 2-byte list; length 0 when none missing
							hdr_byte_d = {cmd_auth, `FMT_REMINDER, cmd_tid};
							tlen_d     = (!any_miss) ? 4'h0 : (hi_miss < 7'h8) ? 4'h1 : 4'h2;
						end
					end
				end
			end
			TX_HDR: begin
				ov_d = 1'b1;
				of_d = 1'b1;
				od_d = hdr_byte_q;
				if (kind_q != PKT_SESSION) begin
					ts_d = TX_FIELD;
				end else if (hdr_byte_q[`HDR_FMT_HI:`HDR_FMT_LO] == `FMT_PREAMBLE ||
						hdr_byte_q[`HDR_FMT_HI:`HDR_FMT_LO] == `FMT_REMINDER) begin
					ts_d = TX_LEN;
				end else if (pay_t_q) begin
					ts_d = TX_PAY;
				end else begin
					ol_d = 1'b1;
					ts_d = TX_IDLE;
				end
			end
			TX_LEN: begin
				ov_d = 1'b1;
				od_d = {4'h0, tlen_q};
				if (tlen_q != 4'h0) begin
					ts_d = TX_LIST;
				end else if (pay_t_q) begin
					ts_d = TX_PAY;
				end else begin
					ol_d = 1'b1;
					ts_d = TX_IDLE;
				end
			end
			TX_LIST: begin
				ov_d   = 1'b1;
				od_d   = tlist_q[tcnt_q[2:0]*8 +: 8];
				tcnt_d = tcnt_q + 4'h1;
				if (tcnt_q + 4'h1 == tlen_q) begin
					if (pair_q) begin
						ol_d       = 1'b1;
						pair_d     = 1'b0;
						hdr_byte_d = {auth_t_q, `FMT_REQUEST, hdr_byte_q[3:0]};
						ts_d       = TX_HDR;
					end else if (pay_t_q) begin
						ts_d = TX_PAY;
					end else begin
						ol_d = 1'b1;
						ts_d = TX_IDLE;
					end
				end
			end
			TX_PAY: begin
				if (pay_valid && pr_q) begin
					ov_d     = 1'b1;
					od_d     = pay_data;
					dig_feed = dig_q;
					if (pay_last) begin
						ol_d = 1'b1;
						ts_d = TX_IDLE;
					end
				end
			end
			TX_FIELD: begin
				ov_d   = 1'b1;
				od_d   = fld_q[7:0];
				fld_d  = {8'h00, fld_q[63:8]};
				tcnt_d = tcnt_q + 4'h1;
				if (tcnt_q + 4'h1 == `AUTH_FIELD_BYTES) begin
					// group byte only for address format 1
					if (taf_q == `ADDR_FMT_GROUP) begin
						ts_d = TX_GROUP;
					end else begin
						ol_d = 1'b1;
						ts_d = TX_IDLE;
					end
				end
			end
			TX_GROUP: begin
				ov_d = 1'b1;
				od_d = tgrp_q;
				ol_d = 1'b1;
				ts_d = TX_IDLE;
			end
			default: ts_d = TX_IDLE;
		endcase
		cr_d = (ts_d == TX_IDLE) && !rep_pend_d && !chal_pend_d && !take_chal && !take_rep;
		pr_d = (ts_d == TX_PAY) && !(ts_q == TX_PAY && pay_valid && pr_q && pay_last);
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ts_q <= TX_IDLE; kind_q <= PKT_SESSION; hdr_byte_q <= 8'h00;
			tlen_q <= 4'h0; tcnt_q <= 4'h0; tlist_q <= '1; fld_q <= 64'h0;
			lfsr_q <= `LFSR_SEED; auth_t_q <= 1'b0; pay_t_q <= 1'b0; pair_q <= 1'b0;
			dig_q <= 1'b0; taf_q <= 2'h0; tgrp_q <= 8'h00;
			ov_q <= 1'b0; of_q <= 1'b0; ol_q <= 1'b0; od_q <= 8'h00;
			cr_q <= 1'b0; pr_q <= 1'b0;
		end else begin
			ts_q <= ts_d; kind_q <= kind_d; hdr_byte_q <= hdr_byte_d;
			tlen_q <= tlen_d; tcnt_q <= tcnt_d; tlist_q <= tlist_d; fld_q <= fld_d;
			lfsr_q <= lfsr_d; auth_t_q <= auth_t_d; pay_t_q <= pay_t_d; pair_q <= pair_d;
			dig_q <= dig_d; taf_q <= taf_d; tgrp_q <= tgrp_d;
			ov_q <= ov_d; of_q <= of_d; ol_q <= ol_d; od_q <= od_d;
			cr_q <= cr_d; pr_q <= pr_d;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// outputs
	assign cmd_ready  = cr_q;
	assign pay_ready  = pr_q;
	assign out_valid  = ov_q;
	assign out_data   = od_q;
	assign out_first  = of_q;
	assign out_last   = ol_q;
	assign out_kind   = kind_q;
	assign rx_hdr     = hdr_q;
	assign rx_auth    = auth_q;
	assign rx_fmt     = rfmt_q;
	assign rx_tid     = rtid_q;
	assign rx_null    = null_q;
	assign rx_done    = done_q;
	assign rx_solicit = sol_q;
	assign rx_err     = err_q;

endmodule : session_auth_framer

// file: session_auth_framer_monitor.sv
module session_auth_framer_monitor (
	// clock and reset
	input	wire logic	clk,
	input	wire logic	nrst,
	// commands
	input	wire logic	cmd_valid,
	input	wire logic	cmd_ready,
	input	wire session_auth_framer_pkg::cmd_kind_type	cmd_kind,
	input	wire logic	cmd_auth,
	input	wire logic [3:0]	cmd_tid,
	// stream out
	input	wire logic	out_valid,
	input	wire logic [7:0]	out_data,
	input	wire logic	out_first,
	input	wire logic	out_last,
	input	wire session_auth_framer_pkg::pkt_kind_type	out_kind,
	// stream in
	input	wire logic	in_valid,
	input	wire logic [7:0]	in_data,
	input	wire logic	in_last,
	input	wire logic	in_is_chal,
	input	wire logic	in_is_session,
	input	wire logic [1:0]	in_addr_fmt,
	// parse results
	input	wire logic	rx_hdr,
	input	wire logic	rx_null
);
	import session_auth_framer_pkg::*;
	logic	mid_q;
	logic	mid_d;
	logic	take;
	logic	hdr;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	assign take = cmd_valid && cmd_ready;
	assign hdr = out_valid && out_first;
	// inside an incoming packet
	always_comb begin
		mid_d = mid_q;
		if (in_valid)
			mid_d = !in_last;
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst)
			mid_q <= 1'b0;
		else
			mid_q <= mid_d;
	end
	////////////////////////////////////////////////////////////////
	req_header_a: assert property (
		take && cmd_kind == CMD_REQUEST |-> ##2 hdr
		&& out_data == {$past(cmd_auth, 2), 3'h0, $past(cmd_tid, 2)}) else $error("request header");
	fmt_known_a: assert property (
		hdr && out_kind == PKT_SESSION |-> out_data[6:4] inside {3'h0, 3'h2, 3'h4, 3'h5})
		else $error("undefined format sent");
	resp_fmt_a: assert property (
		take && cmd_kind == CMD_RESPONSE |-> ##2 hdr && out_data[6:4] == 3'h2)
		else $error("response format");
	retry_fmt_a: assert property (
		take && cmd_kind == CMD_RETRY |-> ##2 hdr && out_data[6:4] != 3'h0)
		else $error("retry used request format");
	pre_len_a: assert property (
		hdr && out_kind == PKT_SESSION && out_data[6:4] == 3'h4 |=> out_valid && !out_last
		&& out_data >= 8'h03 && out_data <= 8'h08) else $error("preamble length");
	chal_hdr_a: assert property (
		in_valid && !mid_q && in_data[7] && !in_is_chal && cmd_ready && !cmd_valid |-> ##3 hdr
		&& out_kind == PKT_CHAL && out_data == {$past(in_addr_fmt, 3), 2'h0, $past(in_data[3:0], 3)})
		else $error("challenge header");
	chal_plain_a: assert property (
		hdr && out_kind == PKT_CHAL && out_data[7:6] != 2'h1 |=> (out_valid && !out_last)[*7]
		##1 out_valid && out_last) else $error("challenge length");
	chal_group_a: assert property (
		hdr && out_kind == PKT_CHAL && out_data[7:6] == 2'h1 |=> (out_valid && !out_last)[*8]
		##1 out_valid && out_last) else $error("challenge group byte");
	reply_hdr_a: assert property (
		hdr && out_kind == PKT_REPLY |-> out_data[5:4] == 2'h2 ##1 (out_valid && !out_last)[*7])
		else $error("reply header");
	null_parse_a: assert property (
		in_valid && !mid_q && in_last && in_is_session && !in_is_chal && in_data[6:4] == 3'h2
		|-> ##[1:2] rx_hdr && rx_null) else $error("header-only parse");
endmodule : session_auth_framer_monitor

bind session_auth_framer session_auth_framer_monitor i_mon (.*);

// file: peer_node_model.sv
module peer_node_model (
	// clock
	input	wire logic	clk,
	// device stream
	input	wire logic	out_valid,
	input	wire logic [7:0]	out_data,
	input	wire logic	out_first,
	input	wire logic	out_last,
	input	wire session_auth_framer_pkg::pkt_kind_type	out_kind,
	// challenge address format
	input	wire logic [1:0]	af,
	// stream to the device
	output	logic	in_valid = 1'b0,
	output	logic [7:0]	in_data = 8'h00,
	output	logic	in_last = 1'b0,
	output	logic	in_is_chal = 1'b0,
	output	logic	in_is_session = 1'b0,
	output	logic [1:0]	in_addr_fmt = 2'h0,
	output	logic [7:0]	in_dst_group = 8'h00
);
	timeunit 1ns;
	timeprecision 1ns;
	import session_auth_framer_pkg::*;
	logic	auth_q;
	logic [3:0]	tid_q;
	logic [7:0]	chal[$];
	logic [7:0]	n_q = 8'h00;

	task automatic send(input logic [7:0] b[$], input logic c, s, input logic [1:0] a,
			input logic [7:0] g);
		@(negedge clk);
		in_is_chal = c;
		in_is_session = s;
		in_addr_fmt = a;
		in_dst_group = g;
		foreach (b[i]) begin
			in_valid = 1'b1;
			in_data = b[i];
			in_last = i == b.size() - 1;
			@(negedge clk);
		end
		in_valid = 1'b0;
		in_last = 1'b0;
		// released bus must not keep the last byte
		in_data = ~in_data;
	endtask : send

	always @(negedge clk) begin
		if (out_valid && out_first && out_kind == PKT_SESSION) begin
			auth_q = out_data[7];
			tid_q = out_data[3:0];
		end
		if (out_valid && out_last && out_kind == PKT_SESSION && auth_q) begin
			chal = '{{af, 2'h0, tid_q}};
			repeat (8) chal.push_back(n_q++);
			if (af == 2'h1)
				chal.push_back(8'h5A);
			send(chal, 1'b1, 1'b1, af, 8'h5A);
		end
	end
endmodule : peer_node_model

// file: test_session_auth_framer.sv
module test_session_auth_framer;
	timeunit 1ns;
	timeprecision 1ns;
	import session_auth_framer_pkg::*;
	logic	clk = 1'b0;
	logic	nrst = 1'b0;
	logic	cmd_valid = 1'b0;
	cmd_kind_type	cmd_kind = CMD_REQUEST;
	logic	cmd_auth = 1'b0;
	logic	cmd_has_pay = 1'b0;
	logic [3:0]	cmd_tid = 4'h0;
	logic [3:0]	cmd_list_len = 4'h0;
	logic [63:0]	cmd_list = 64'h0;
	logic	pay_valid = 1'b0;
	logic [7:0]	pay_data = 8'h00;
	logic	pay_last = 1'b0;
	logic [47:0]	auth_key = 48'h0123_4567_89AB;
	logic [5:0]	my_member = 6'h03;
	logic [1:0]	peer_af = 2'h1;
	logic	cmd_ready, pay_ready, out_valid, out_first, out_last, in_valid, in_last;
	logic	in_is_chal, in_is_session, rx_hdr, rx_auth, rx_null, rx_done, rx_solicit, rx_err;
	logic [7:0]	out_data, in_data, in_dst_group;
	logic [1:0]	in_addr_fmt;
	logic [2:0]	rx_fmt;
	logic [3:0]	rx_tid;
	pkt_kind_type	out_kind;
	logic [11:0]	outq[$];
	logic [7:0]	payq[$];
	logic [9:0]	rxq[$];
	logic [11:0]	n;
	logic [8:0]	hdr_seen;
	logic [31:0]	seed = 32'h0000_001B;
	int	failures = 0;
	int	cmp_count = 0;
	int	errs = 0;

	session_auth_framer i_dut (.*);
	peer_node_model i_peer (.*, .af(peer_af));

	initial begin
		forever #10 clk = ~clk;
	end

	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction : rnd

	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : end_sim

	task automatic cmp(input string what, input logic [10:0] exp, got);
		cmp_count++;
		if (exp !== got) begin
			failures++;
			$display("wrong value %s expected %h seen %h", what, exp, got);
		end
	endtask : cmp

	task automatic note(input logic chk, last, input pkt_kind_type k, input logic [7:0] d);
		outq.push_back({chk, last, k, d});
	endtask : note

	task automatic wait_idle();
		int i;
		for (i = 0; i < 400 && (outq.size() + payq.size() + rxq.size() != 0 || !cmd_ready); i++)
			@(negedge clk);
		if (i == 400) begin
			failures++;
			end_sim();
		end
		repeat (3) @(negedge clk);
	endtask : wait_idle

	task automatic command(input cmd_kind_type k, input logic a, input logic [3:0] len,
			input logic [63:0] lst, input int np);
		logic [3:0] t;
		logic [7:0] p;
		int hi, ln, i;
		t = 4'(rnd());
		hi = -1;
		for (i = 0; i < len * 8; i++)
			if (!lst[i]) hi = i;
		if (k == CMD_RETRY && hi >= 16) begin
			note(1'b1, 1'b0, PKT_SESSION, {a, 3'h4, t});
			note(1'b1, 1'b0, PKT_SESSION, 8'(len));
			for (i = 0; i < len; i++)
				note(1'b1, i == len - 1, PKT_SESSION, lst[i*8 +: 8]);
			note(1'b1, 1'b0, PKT_SESSION, {a, 3'h0, t});
		end else if (k == CMD_RETRY) begin
			ln = hi < 0 ? 0 : hi < 8 ? 1 : 2;
			note(1'b1, 1'b0, PKT_SESSION, {a, 3'h5, t});
			note(1'b1, 1'b0, PKT_SESSION, 8'(ln));
			for (i = 0; i < ln; i++)
				note(1'b1, 1'b0, PKT_SESSION, lst[i*8 +: 8]);
		end else
			note(1'b1, np == 0, PKT_SESSION, {a, k == CMD_RESPONSE ? 3'h2 : 3'h0, t});
		for (i = 0; i < np; i++) begin
			p = rnd();
			payq.push_back(p);
			note(1'b1, i == np - 1, PKT_SESSION, p);
		end
		if (a) begin
			note(1'b1, 1'b0, PKT_REPLY, {peer_af, 2'h2, t});
			for (i = 0; i < 8; i++)
				note(1'b0, i == 7 && peer_af != 2'h1, PKT_REPLY, 8'h00);
			if (peer_af == 2'h1)
				note(1'b1, 1'b1, PKT_REPLY, 8'h5A);
		end
		cmd_kind = k;
		cmd_auth = a;
		cmd_tid = t;
		cmd_list_len = len;
		cmd_list = lst;
		cmd_has_pay = np != 0;
		cmd_valid = 1'b1;
		for (i = 0; i < 50 && cmd_ready !== 1'b1; i++)
			@(negedge clk);
		failures += int'(i == 50);
		@(negedge clk);
		cmd_valid = 1'b0;
		wait_idle();
	endtask : command

	////////////////////////////////////////////////////////////////
	// payload source, held until taken
	initial begin
		forever begin
			@(negedge clk);
			pay_valid = payq.size() != 0;
			if (pay_valid) begin
				pay_data = payq[0];
				pay_last = payq.size() == 1;
			end
			if (pay_valid && pay_ready)
				void'(payq.pop_front());
		end
	end

	// result watcher
	always @(negedge clk) begin
		if (out_valid) begin
			n = outq.size() != 0 ? outq.pop_front() : 12'hFFF;
			cmp("out byte", n[11] ? n[10:0] : {n[10:8], 8'h00},
				{out_last, out_kind, n[11] ? out_data : 8'h00});
		end
		if (rx_err)
			errs++;
		if (rx_hdr)
			hdr_seen = {rx_auth, rx_fmt, rx_tid, rx_null};
		if (rx_done && rxq.size() != 0)
			cmp("rx result", {1'b0, rxq.pop_front()}, {1'b0, hdr_seen, rx_solicit});
	end

	////////////////////////////////////////////////////////////////
	initial begin
		int i;
		repeat (6) @(posedge clk);
		@(negedge clk);
		nrst = 1'b1;
		command(CMD_REQUEST, 1'b0, 4'h0, 64'h0, 2);
		command(CMD_RESPONSE, 1'b0, 4'h0, 64'h0, 0);
		for (i = 1; i < 3; i++) begin
			peer_af = 2'(i);
			command(CMD_RESPONSE, 1'b1, 4'h0, 64'h0, 3);
			command(CMD_REQUEST, 1'b1, 4'h0, 64'h0, 1);
		end
		command(CMD_RETRY, 1'b0, 4'h3, ~(64'h1 << 20), 2);
		command(CMD_RETRY, 1'b0, 4'h8, ~(64'h1 << 63), 1);
		command(CMD_RETRY, 1'b0, 4'h1, ~64'h8, 1);
		command(CMD_RETRY, 1'b0, 4'h2, ~(64'h1 << 15), 1);
		command(CMD_RETRY, 1'b0, 4'h1, ~64'h0, 1);
		for (i = 1; i < 3; i++) begin
			n[3:0] = 4'(rnd());
			note(1'b1, 1'b0, PKT_CHAL, {2'(i), 2'h0, n[3:0]});
			for (int j = 0; j < 8; j++)
				note(1'b0, j == 7 && i == 2, PKT_CHAL, 8'h00);
			if (i == 1)
				note(1'b1, 1'b1, PKT_CHAL, 8'h3C);
			i_peer.send('{{1'b1, 3'h0, n[3:0]}, 8'h21}, 1'b0, 1'b1, 2'(i), 8'h3C);
			wait_idle();
		end
		rxq = '{10'h141, 10'h14C, 10'h141, 10'h083};
		i_peer.send('{8'h50, 8'h00, 8'h21}, 1'b0, 1'b1, 2'h2, 8'h00);
		i_peer.send('{8'h53, 8'h01, 8'h08, 8'h21}, 1'b0, 1'b1, 2'h2, 8'h00);
		i_peer.send('{8'h50, 8'h01, 8'hF7, 8'h21}, 1'b0, 1'b1, 2'h2, 8'h00);
		i_peer.send('{8'h20}, 1'b0, 1'b1, 2'h2, 8'h00);
		wait_idle();
		i = errs;
		i_peer.send('{8'h30, 8'h21}, 1'b0, 1'b1, 2'h2, 8'h00);
		wait_idle();
		cmp("format error", 11'(i + 1), 11'(errs));
		end_sim();
	end
endmodule : test_session_auth_framer
